// ===== logic/sprt_pkg.sv
package sprt_pkg;

  // ************************************************************
  // clocking
  // ************************************************************
  localparam int unsigned SYS_CLK_MHZ       = 250;

  // ************************************************************
  // timing figures in their own units
  // ************************************************************
  localparam int unsigned RESET_MIN_NS      = 500;
  localparam int unsigned REG_ACQ_TYP_US    = 44;
  localparam int unsigned REG_ACQ_MAX_US    = 114;
  localparam int unsigned POR_TYP_US        = 250;
  localparam int unsigned READY_HIGH_MCLK   = 4;
  localparam int unsigned TIMEOUT_DIAGNOSTIC_OSCILLATOR      = 16385;

  // ************************************************************
  // derived cycle counts
  // ************************************************************
  localparam int unsigned RESET_MIN_CYC =
    (RESET_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned REG_ACQ_CYC   = REG_ACQ_TYP_US * SYS_CLK_MHZ;
  localparam int unsigned POR_CYC       = POR_TYP_US * SYS_CLK_MHZ;

  localparam int unsigned CNT_W         = 17;
  localparam int unsigned RST_CNT_W     = 8;
  localparam int unsigned TO_CNT_W      = 15;
  localparam int unsigned PULSE_CNT_W   = 3;
  localparam int unsigned BIT_CNT_W     = 5;
  localparam int unsigned WORD_W        = 24;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    SPRT_WAIT_POR,
    SPRT_ACQ,
    SPRT_RUN
  } sprt_state_t;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] data;
  } sprt_word_t;

endpackage

// ===== logic/sprt_port.sv
`timescale 1ns/10ps
// Summary of operation
// R1: input data is sampled on each serial clock falling edge while selected.
// R2: output data changes after each serial clock rising edge for a fall read.
// R3: the output is driven only while select is low, released when it rises.
// R4: a hard reset low for at least the minimum width resets the whole device; the code clears only the sequencer, link shift registers and output enable.
// R5: after hard reset release defaults are reloaded, then ready goes high.
// R6: after power-on release ready goes high after the power-on delay.
// R7: each high pulse of the ready line lasts four main-clock periods.
// R8: an idle partial frame is dropped after the timeout in oscillator periods.
module sprt_port
  import sprt_pkg::*;
#(
  parameter int unsigned REG_ACQ_CYCLES = REG_ACQ_CYC,
  parameter int unsigned POR_CYCLES     = POR_CYC,
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_DIAGNOSTIC_OSCILLATOR
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              hard_reset_low_i,
  input  wire logic              diagnostic_oscillator_i,
  input  wire logic              serial_clk_i,
  input  wire logic              select_low_i,
  input  wire logic              serial_in_i,
  input  wire logic [WORD_W-1:0] tx_word_i,
  output logic                   serial_out_o,
  output logic                   serial_out_oe_o,
  output logic                   conversion_done_low_o,
  output logic                   host_ready_o,
  output logic                   rx_valid_o,
  output logic [WORD_W-1:0]      rx_word_o
);

  // ************************************************************
  // hard reset pin: synchronise, then qualify pulse width
  // ************************************************************
  logic                 hr_s1_q, hr_s2_q;
  logic [RST_CNT_W-1:0] hr_cnt_q, hr_cnt_d;
  logic                 hr_arm_q, hr_arm_d;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hr_s1_q <= 1'b1;
      hr_s2_q <= 1'b1;
    end else begin
      hr_s1_q <= hard_reset_low_i;
      hr_s2_q <= hr_s1_q;
    end
  end

  // a glitch shorter than the minimum never arms the reset
  always_comb begin
    hr_cnt_d = hr_cnt_q;
    hr_arm_d = hr_arm_q;
    if (!hr_s2_q) begin
      if (hr_cnt_q != RST_CNT_W'(RESET_MIN_CYC - 1))
        hr_cnt_d = hr_cnt_q + 1'b1;
      else
        hr_arm_d = 1'b1; // R4
    end else begin
      hr_cnt_d = '0;
      hr_arm_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hr_cnt_q <= '0;
      hr_arm_q <= 1'b0;
    end else begin
      hr_cnt_q <= hr_cnt_d;
      hr_arm_q <= hr_arm_d;
    end
  end

  // ************************************************************
  // power-on / acquisition sequencer and ready pulse
  // ************************************************************
  sprt_state_t            st_q, st_d;
  logic [CNT_W-1:0]       dly_q, dly_d;
  logic [PULSE_CNT_W-1:0] pls_q, pls_d;
  logic                   dev_rst, rx_evt;

  assign dev_rst = hr_arm_q | ~hr_s2_q & hr_arm_d;

  always_comb begin
    st_d  = st_q;
    dly_d = dly_q;
    pls_d = (pls_q != '0) ? pls_q - 1'b1 : pls_q;
    if (hr_arm_q) begin
      st_d  = SPRT_ACQ; // R4
      dly_d = '0;
      pls_d = '0;
    end else begin
      unique case (st_q)
        SPRT_WAIT_POR: begin
          if (dly_q == CNT_W'(POR_CYCLES - 1)) begin
            st_d  = SPRT_RUN; // R6
            pls_d = PULSE_CNT_W'(READY_HIGH_MCLK); // R7
          end else
            dly_d = dly_q + 1'b1;
        end
        SPRT_ACQ: begin
          if (dly_q == CNT_W'(REG_ACQ_CYCLES - 1)) begin
            st_d  = SPRT_RUN; // R5
            pls_d = PULSE_CNT_W'(READY_HIGH_MCLK); // R7
          end else
            dly_d = dly_q + 1'b1;
        end
        SPRT_RUN: begin
          if (rx_evt)
            pls_d = PULSE_CNT_W'(READY_HIGH_MCLK); // R7
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q  <= SPRT_WAIT_POR;
      dly_q <= '0;
      pls_q <= '0;
    end else begin
      st_q  <= st_d;
      dly_q <= dly_d;
      pls_q <= pls_d;
    end
  end

  assign conversion_done_low_o = (pls_q != '0) | (st_q != SPRT_RUN);
  assign host_ready_o          = (st_q == SPRT_RUN);

  // ************************************************************
  // link domain: shift registers on the serial clock
  // ************************************************************
  logic [WORD_W-1:0]    rx_sh_q, rx_sh_d;
  logic [BIT_CNT_W-1:0] bit_q, bit_d;
  logic [WORD_W-1:0]    tx_sh_q, tx_sh_d;
  logic                 out_q, out_d;
  logic                 done_tg_q, done_tg_d;
  logic [WORD_W-1:0]    hold_q, hold_d;
  logic                 abort_s1_q, abort_s2_q;
  logic                 lnk_rst_b;

  // select high, frame drop or hard reset clear the link without its clock
  assign lnk_rst_b = rst_b_i & ~select_low_i & ~abort_s2_q & ~hr_arm_q;

  always_comb begin
    rx_sh_d   = {rx_sh_q[WORD_W-2:0], serial_in_i}; // R1
    bit_d     = bit_q + 1'b1;
    done_tg_d = done_tg_q;
    hold_d    = hold_q;
    if (bit_q == BIT_CNT_W'(WORD_W - 1)) begin
      bit_d     = '0;
      hold_d    = rx_sh_d;
      done_tg_d = ~done_tg_q;
    end
  end

  always_ff @(negedge serial_clk_i or negedge lnk_rst_b) begin
    if (!lnk_rst_b) begin
      rx_sh_q <= '0;
      bit_q   <= '0;
    end else begin
      rx_sh_q <= rx_sh_d;
      bit_q   <= bit_d;
    end
  end

  // toggle and word holder survive frame end for the crossing
  always_ff @(negedge serial_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_tg_q <= 1'b0;
      hold_q    <= '0;
    end else begin
      done_tg_q <= done_tg_d;
      hold_q    <= hold_d;
    end
  end

  // first bit is presented on the first rising edge, taken from tx_word_i while bit_q is zero
  always_comb begin
    tx_sh_d = {tx_sh_q[WORD_W-2:0], 1'b0};
    out_d   = tx_sh_q[WORD_W-1]; // R2
    if (bit_q == '0) begin
      tx_sh_d = {tx_word_i[WORD_W-2:0], 1'b0};
      out_d   = tx_word_i[WORD_W-1];
    end
  end

  always_ff @(posedge serial_clk_i or negedge lnk_rst_b) begin
    if (!lnk_rst_b) begin
      tx_sh_q <= '0;
      out_q   <= 1'b0;
    end else begin
      tx_sh_q <= tx_sh_d;
      out_q   <= out_d; // R2
    end
  end

  assign serial_out_o    = out_q;
  assign serial_out_oe_o = ~select_low_i & rst_b_i & ~dev_rst; // R3

  // ************************************************************
  // crossing into the system domain
  // ************************************************************
  logic              tg_s1_q, tg_s2_q, tg_s3_q;
  sprt_word_t        rx_q, rx_d;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
    end else begin
      tg_s1_q <= done_tg_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
    end
  end

  assign rx_evt = tg_s2_q ^ tg_s3_q;

  // hold_q is stable for many system cycles once the toggle lands
  always_comb begin
    rx_d.valid = rx_evt;
    rx_d.data  = rx_evt ? hold_q : rx_q.data;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      rx_q <= '0;
    else
      rx_q <= rx_d;
  end

  assign rx_valid_o = rx_q.valid;
  assign rx_word_o  = rx_q.data;

  // ************************************************************
  // idle timeout on the diagnostic oscillator
  // ************************************************************
  logic                osc_s1_q, osc_s2_q, osc_s3_q;
  logic                sck_s1_q, sck_s2_q, sck_s3_q;
  logic                cs_s1_q, cs_s2_q;
  logic [TO_CNT_W-1:0] to_q, to_d;
  logic                abort_q, abort_d;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {osc_s1_q, osc_s2_q, osc_s3_q} <= 3'h0;
      {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
      {cs_s1_q, cs_s2_q}             <= 2'h3;
    end else begin
      osc_s1_q <= diagnostic_oscillator_i;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      sck_s1_q <= serial_clk_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      cs_s1_q  <= select_low_i;
      cs_s2_q  <= cs_s1_q;
    end
  end

  always_comb begin
    to_d    = to_q;
    abort_d = abort_q;
    if (cs_s2_q || (sck_s2_q != sck_s3_q)) begin
      to_d    = '0;
      abort_d = 1'b0; // R8
    end else if (osc_s2_q && !osc_s3_q) begin
      if (to_q == TO_CNT_W'(TIMEOUT_CYCLES - 1))
        abort_d = 1'b1; // R8
      else
        to_d = to_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      to_q    <= '0;
      abort_q <= 1'b0;
    end else begin
      to_q    <= to_d;
      abort_q <= abort_d;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      abort_s1_q <= 1'b0;
      abort_s2_q <= 1'b0;
    end else begin
      abort_s1_q <= abort_q;
      abort_s2_q <= abort_s1_q;
    end
  end

endmodule

// ===== testbench/sprt_host.sv
`timescale 1ns/10ps
// ****
// serial host model
// ****
module sprt_host (
  output logic      select_low_o,
  output logic      serial_clk_o,
  output logic      serial_in_o,
  input  wire logic serial_out_i,
  input  wire logic serial_out_oe_i
);
  initial begin
    select_low_o = 1'b1;
    serial_clk_o = 1'b0;
    serial_in_o  = 1'b0;
  end

  // n bits msb first; clock held low w ns before bit p
  task automatic xfer(input logic [47:0] d, input int n, p, w,
                      output logic [23:0] got);
    got = 24'h0;
    select_low_o = 1'b0;
    #60;
    for (int i = n - 1; i >= 0; i--) begin
      if (i == n - 1 - p) #(w);
      serial_clk_o = 1'b1;
      serial_in_o  = d[i];
      #62.5;
      serial_clk_o = 1'b0;
      got = {got[22:0], serial_out_oe_i ? serial_out_i : 1'bx};
      #62.5;
    end
    #20;
    select_low_o = 1'b1;
    // released line must not keep the last bit
    serial_in_o  = ~serial_in_o;
    // select-high gap, so a following frame never merges with this one
    #40;
  endtask
endmodule

// ===== testbench/sprt_port_chk.sv
`timescale 1ns/10ps
// ****
// port checker
// ****
module sprt_port_chk
  import sprt_pkg::*;
#(
  parameter int unsigned POR_CYCLES     = POR_CYC,
  parameter int unsigned REG_ACQ_CYCLES = REG_ACQ_CYC
) (
  input wire logic              sys_clk_i,
  input wire logic              rst_b_i,
  input wire logic              hard_reset_low_i,
  input wire logic              select_low_i,
  input wire logic              serial_out_oe_o,
  input wire logic              conversion_done_low_o,
  input wire logic              host_ready_o,
  input wire logic              rx_valid_o,
  input wire logic [WORD_W-1:0] rx_word_o
);
  logic [16:0] cnt_q;
  logic [16:0] cnt_d;
  logic        seen_q;
  logic        seen_d;

  // cycles spent not ready since the last reset of either kind
  always_comb begin
    cnt_d = host_ready_o ? 17'h0 : cnt_q + 17'h1;
    if (!hard_reset_low_i) cnt_d = 17'h0;
    seen_d = seen_q | host_ready_o;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q  <= 17'h0;
      seen_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      seen_q <= seen_d;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_oe_idle: assert property (select_low_i |-> !serial_out_oe_o)
    else $error("output driven while deselected");
  a_oe_drive: assert property (!select_low_i && host_ready_o
    |-> serial_out_oe_o) else $error("output not driven while selected");
  a_por_time: assert property ($rose(host_ready_o) && !seen_q
    |-> cnt_q inside {[POR_CYCLES-2:POR_CYCLES+2]})
    else $error("power-on delay wrong");
  a_acq_time: assert property ($rose(host_ready_o) && seen_q
    |-> cnt_q inside {[REG_ACQ_CYCLES:REG_ACQ_CYCLES+4]})
    else $error("acquisition delay wrong");
  a_run_pulse: assert property ($rose(host_ready_o)
    |-> conversion_done_low_o[*4] ##1 !conversion_done_low_o)
    else $error("ready pulse at start wrong");
  a_word_pulse: assert property ($rose(conversion_done_low_o)
    && host_ready_o |-> conversion_done_low_o[*4] ##1
    !conversion_done_low_o) else $error("ready pulse width wrong");
  a_boot_high: assert property (!host_ready_o
    |-> conversion_done_low_o) else $error("ready low while booting");
  a_valid_once: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("valid longer than one cycle");
  a_word_hold: assert property (host_ready_o && !$stable(rx_word_o)
    |-> rx_valid_o || $past(rx_valid_o)) else $error("word changed");
  a_valid_done: assert property (rx_valid_o
    |-> ##[1:3] conversion_done_low_o) else $error("no ready pulse");
endmodule

bind sprt_port sprt_port_chk #(
  .POR_CYCLES    (POR_CYCLES),
  .REG_ACQ_CYCLES(REG_ACQ_CYCLES)
) chk_u (.sys_clk_i, .rst_b_i, .hard_reset_low_i, .select_low_i,
  .serial_out_oe_o, .conversion_done_low_o, .host_ready_o, .rx_valid_o,
  .rx_word_o);

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
// ****
// bench
// ****
module tb_top;
  import sprt_pkg::*;
  localparam int POR = 50;
  localparam int ACQ = 40;
  logic        clk, rst_b, hrst_low, osc, sclk, sel_low, sdi;
  logic        sdo, sdo_oe, done_low, ready, rx_valid;
  logic [23:0] tx_word, rx_word, got;
  logic [47:0] d;
  int          n_errors, total_checks, n_rx, n_hi, c, h, k;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // diagnostic oscillator, 40 ns period chosen freely
  initial begin
    osc = 1'b0;
    forever #20 osc = ~osc;
  end
  always @(posedge clk) begin
    if (rx_valid === 1'b1) n_rx++;
    if (done_low === 1'b1 && ready === 1'b1) n_hi++;
  end

  sprt_port #(.REG_ACQ_CYCLES(ACQ), .POR_CYCLES(POR),
    .TIMEOUT_CYCLES(20)) dut_u (.sys_clk_i(clk), .rst_b_i(rst_b),
    .hard_reset_low_i(hrst_low), .diagnostic_oscillator_i(osc),
    .serial_clk_i(sclk), .select_low_i(sel_low), .serial_in_i(sdi),
    .tx_word_i(tx_word), .serial_out_o(sdo), .serial_out_oe_o(sdo_oe),
    .conversion_done_low_o(done_low), .host_ready_o(ready),
    .rx_valid_o(rx_valid), .rx_word_o(rx_word));
  sprt_host host_u (.select_low_o(sel_low), .serial_clk_o(sclk),
    .serial_in_o(sdi), .serial_out_i(sdo), .serial_out_oe_i(sdo_oe));

  task stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [23:0] s, e, input string nm);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait for ready (t<0) or for t received words
  task wait_for(input int t);
    c = 0;
    while ((t < 0 ? ready !== 1'b1 : n_rx != t) && c < 200) begin
      cyc(1);
      c++;
    end
    if (c == 200) begin
      n_errors++;
      stop_test;
    end
  endtask
  task frame(input int n, p, w, nrx);
    host_u.xfer(d, n, p, w, got);
    wait_for(nrx);
    cyc(8);
    check(rx_word, d[23:0], "rx_word");
  endtask

  initial begin
    void'($urandom(32'h9eaf42e8));
    {rst_b, n_errors, total_checks, n_rx, n_hi} = '0;
    hrst_low = 1'b1;
    tx_word  = 24'h0;
    d        = 48'h0;
    cyc(4);
    rst_b = 1'b1;
    wait_for(-1);
    check(24'(c >= POR - 2 && c <= POR + 2), 24'h1, "por_time");
    cyc(8);
    check(24'(done_low), 24'h0, "ready_low");
    for (k = 0; k < 6; k++) begin
      tx_word = k < 2 ? {24{k[0]}} : 24'($urandom);
      d = k < 2 ? {48{k[0]}} : {$urandom, $urandom};
      h = n_hi;
      frame(24, 12, k * 60, k + 1);
      check(got, tx_word, "tx_bits");
      check(24'(n_hi - h), 24'h4, "ready_high");
    end
    d = {$urandom, $urandom};
    frame(48, 0, 0, 8);
    check(got, tx_word, "tx_bits_b2b");
    host_u.xfer(d, 10, 0, 0, got);
    d = {$urandom, $urandom};
    frame(24, 0, 0, 9);
    frame(34, 10, 2000, 10);
    cyc(20);
    check(24'(n_rx), 24'd10, "word_count");
    hrst_low = 1'b0;
    cyc(RESET_MIN_CYC + 5);
    check(24'(ready), 24'h0, "hard_reset");
    hrst_low = 1'b1;
    wait_for(-1);
    check(24'(c >= ACQ && c <= ACQ + 4), 24'h1, "acq_time");
    cyc(8);
    stop_test;
  end
endmodule
